/* design/dual_bidirectional_io_ports.sv */
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none

module dual_bidirectional_io_ports
   import gpio_ports_pkg::*;
#(
   parameter int PA_WIDTH = PA_PINS,
   parameter int PB_WIDTH = PB_PINS
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic [AXI_ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [AXI_DATA_W-1:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [AXI_ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [AXI_DATA_W-1:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic [PA_WIDTH-1:0] PA_IN,
   output logic [PA_WIDTH-1:0] PA_OUT,
   output logic [PA_WIDTH-1:0] PA_OE,
   output logic [PA_WIDTH-1:0] PA_PULLUP,
   output logic [PA_WIDTH-1:0] PA_SLOW,
   input wire logic [PB_WIDTH-1:0] PB_IN,
   output logic [PB_WIDTH-1:0] PB_OUT,
   output logic [PB_WIDTH-1:0] PB_OE,
   output logic [PB_WIDTH-1:0] PB_PULLUP,
   output logic [PB_WIDTH-1:0] PB_SLOW,
   output logic PRIMARY_EXT_IRQ,
   output logic SECONDARY_EXT_IRQ,
   output logic CAPTURE_IN,
   output logic IRQ
);

   // The register map and pin sharing are fixed to the documented widths.
   if (PA_WIDTH != PA_PINS || PB_WIDTH != PB_PINS) begin : g_width_check
      $error("Port widths must be 8 and 5.");
   end

   logic [7:0] pa_latch_reg;
   logic [4:0] pb_latch_reg;
   logic [7:0] pa_dir_reg;
   logic [4:0] pb_dir_reg;
   logic slow_a_reg;
   logic slow_b_reg;
   logic [7:0] pa_pu_reg;
   logic [4:0] pb_pu_reg;
   logic [IRQ_BITS-1:0] irq_status_reg;
   logic [IRQ_BITS-1:0] irq_enable_reg;
   logic [2:0] conv_ctrl_reg;
   logic [7:0] pa_in_prev_reg;

   logic [AXI_ADDR_W-1:0] aw_addr_reg;
   logic [7:0] wdata_reg;
   logic wstrb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [AXI_DATA_W-1:0] rdata_reg;

   logic [7:0] pa_oe_reg;
   logic [7:0] pa_out_reg;
   logic [4:0] pb_oe_reg;
   logic [4:0] pb_out_reg;
   logic [4:0] pb_force;
   logic [4:0] pb_dir_eff;
   logic [4:0] pb_pu_eff;
   logic [7:0] pa_read;
   logic [4:0] pb_read;
   logic wr_fire;
   logic wr_open_reg;
   logic [4:0] wr_idx;
   logic wr_ok;
   logic [IRQ_BITS-1:0] irq_event;
   logic [IRQ_BITS-1:0] irq_status_next;

   function automatic logic addr_ok(input logic [AXI_ADDR_W-1:0] a);
      logic [4:0] i;
      i = a[6:2];
      addr_ok = (a[7] == 1'b0) && (a[1:0] == 2'b00) &&
         (i == IDX_PA_DATA || i == IDX_PB_DATA || i == IDX_PA_DIR || i == IDX_PB_DIR ||
          i == IDX_PA_PULLUP || i == IDX_PB_PULLUP || i == IDX_IRQ_STATUS ||
          i == IDX_IRQ_CLEAR || i == IDX_IRQ_ENABLE || i == IDX_CONV_CTRL);
   endfunction

   // A converter pin is taken over only while the converter is on and the channel selected.
   always_comb begin
      pb_force = 5'h00;
      pb_force[PB_CONV_FOUR_BIT] = conv_ctrl_reg[CONV_ON_BIT] & conv_ctrl_reg[CONV_SEL_FOUR_BIT];
      pb_force[PB_CONV_FIVE_BIT] = conv_ctrl_reg[CONV_ON_BIT] & conv_ctrl_reg[CONV_SEL_FIVE_BIT];
   end

   assign pb_dir_eff = pb_dir_reg & ~pb_force;
   assign pb_pu_eff = pb_pu_reg & ~pb_force;

   // Output pins read back the latch, inputs the pin; the select is never unknown after reset.
   genvar g;
   for (g = 0; g < 8; g++) begin : g_pa_read
      assign pa_read[g] = pa_dir_reg[g] ? pa_latch_reg[g] : PA_IN[g];
   end
   for (g = 0; g < 5; g++) begin : g_pb_read
      assign pb_read[g] = pb_dir_eff[g] ? pb_latch_reg[g] : PB_IN[g];
   end

   // Write channel: address and data are held until both are present.
   // Both readies are low during reset too, so the fire term waits until the channels have been
   // opened once; otherwise the first cycle after reset would answer a write nobody made.
   assign wr_fire = wr_open_reg && !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_idx = aw_addr_reg[6:2];
   assign wr_ok = addr_ok(aw_addr_reg);

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         aw_addr_reg <= '0;
         wdata_reg <= 8'h00;
         wstrb_reg <= 1'b0;
      end else begin
         if (!wr_open_reg) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && BREADY) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
         if (awready_reg && AWVALID) begin
            awready_reg <= 1'b0;
            aw_addr_reg <= AWADDR;
         end
         if (wready_reg && WVALID) begin
            wready_reg <= 1'b0;
            wdata_reg <= WDATA[7:0];
            wstrb_reg <= WSTRB[0];
         end
      end
   end

   // The first cycle after reset opens both write channels; later the response path reopens them.
   // A master may therefore offer its first write from the second edge after release.
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         wr_open_reg <= 1'b0;
      end else begin
         wr_open_reg <= 1'b1;
      end
   end

   // Read channel: data is captured when the address is taken.
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
      end else if (arready_reg && ARVALID) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= addr_ok(ARADDR) ? RESP_OKAY : RESP_SLVERR;
         rdata_reg <= '0;
         if (addr_ok(ARADDR)) begin
            case (ARADDR[6:2])
               IDX_PA_DATA: rdata_reg[7:0] <= pa_read;
               IDX_PB_DATA: rdata_reg[4:0] <= pb_read;
               IDX_PA_DIR: rdata_reg[7:0] <= pa_dir_reg;
               IDX_PB_DIR: rdata_reg[7:0] <= {slow_a_reg, slow_b_reg, 1'b0, pb_dir_reg};
               IDX_IRQ_STATUS: rdata_reg[IRQ_BITS-1:0] <= irq_status_reg;
               IDX_IRQ_ENABLE: rdata_reg[IRQ_BITS-1:0] <= irq_enable_reg;
               IDX_CONV_CTRL: rdata_reg[2:0] <= conv_ctrl_reg;
               default: rdata_reg <= '0;
            endcase
         end
      end else if (rvalid_reg && RREADY) begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end else if (!rvalid_reg) begin
         arready_reg <= 1'b1;
      end
   end

   // Latches carry no reset and take every write with WSTRB[0] set, regardless of direction.
   always_ff @(posedge MCLK) begin
      if (wr_fire && wr_ok && wstrb_reg) begin
         if (wr_idx == IDX_PA_DATA) begin
            pa_latch_reg <= wdata_reg;
         end
         if (wr_idx == IDX_PB_DATA) begin
            pb_latch_reg <= wdata_reg[4:0];
         end
      end
   end

   // Configuration changes only on a bus write, so an idle core leaves every pin as it was.
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         pa_dir_reg <= RST_DIR;
         pb_dir_reg <= RST_DIR[4:0];
         slow_a_reg <= 1'b0;
         slow_b_reg <= 1'b0;
         pa_pu_reg <= RST_PULLUP;
         pb_pu_reg <= RST_PULLUP[4:0];
         irq_enable_reg <= RST_IRQ;
         conv_ctrl_reg <= RST_CONV;
      end else if (wr_fire && wr_ok && wstrb_reg) begin
         case (wr_idx)
            IDX_PA_DIR: pa_dir_reg <= wdata_reg;
            IDX_PB_DIR: begin
               pb_dir_reg <= wdata_reg[4:0];
               slow_a_reg <= wdata_reg[PB_DIR_SLOW_A_BIT];
               slow_b_reg <= wdata_reg[PB_DIR_SLOW_B_BIT];
            end
            IDX_PA_PULLUP: pa_pu_reg <= wdata_reg;
            IDX_PB_PULLUP: pb_pu_reg <= wdata_reg[4:0];
            IDX_IRQ_ENABLE: irq_enable_reg <= wdata_reg[IRQ_BITS-1:0];
            IDX_CONV_CTRL: conv_ctrl_reg <= wdata_reg[2:0];
            default: pa_dir_reg <= pa_dir_reg;
         endcase
      end
   end

   // Falling edges on first-port input pins 0 to 4 set the interrupt status bits; output pins are masked out.
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         pa_in_prev_reg <= 8'hFF;
      end else begin
         pa_in_prev_reg <= PA_IN;
      end
   end

   always_comb begin
      irq_event = '0;
      irq_event[IRQ_PRIMARY_BIT] = |(pa_in_prev_reg[PA_PRIMARY_HI_BIT:PA_PRIMARY_LO_BIT] &
         ~PA_IN[PA_PRIMARY_HI_BIT:PA_PRIMARY_LO_BIT] &
         ~pa_dir_reg[PA_PRIMARY_HI_BIT:PA_PRIMARY_LO_BIT]);
      irq_event[IRQ_SECONDARY_BIT] = pa_in_prev_reg[PA_SECONDARY_BIT] &
         ~PA_IN[PA_SECONDARY_BIT] & ~pa_dir_reg[PA_SECONDARY_BIT];
      irq_status_next = irq_status_reg;
      if (wr_fire && wr_ok && wstrb_reg && wr_idx == IDX_IRQ_CLEAR) begin
         irq_status_next = irq_status_next & ~wdata_reg[IRQ_BITS-1:0];
      end
      // A new event in the clearing cycle is kept.
      irq_status_next = irq_status_next | irq_event;
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         irq_status_reg <= RST_IRQ;
         IRQ <= 1'b0;
      end else begin
         irq_status_reg <= irq_status_next;
         IRQ <= |(irq_status_next & irq_enable_reg);
      end
   end

   // Low level on an input pin is the request level handed to the interrupt logic.
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         PRIMARY_EXT_IRQ <= 1'b0;
         SECONDARY_EXT_IRQ <= 1'b0;
         CAPTURE_IN <= 1'b0;
      end else begin
         PRIMARY_EXT_IRQ <= |(~PA_IN[PA_PRIMARY_HI_BIT:PA_PRIMARY_LO_BIT] &
            ~pa_dir_reg[PA_PRIMARY_HI_BIT:PA_PRIMARY_LO_BIT]);
         SECONDARY_EXT_IRQ <= ~PA_IN[PA_SECONDARY_BIT] & ~pa_dir_reg[PA_SECONDARY_BIT];
         CAPTURE_IN <= pb_dir_eff[PB_CAPTURE_BIT] ? 1'b0 : PB_IN[PB_CAPTURE_BIT];
      end
   end

   // Pin drivers: open drain drives only a low, so a one in the latch releases the pin.
   for (g = 0; g < 8; g++) begin : g_pa_pin
      always_ff @(posedge MCLK) begin
         if (!RSTN) begin
            pa_oe_reg[g] <= 1'b0;
            pa_out_reg[g] <= 1'b0;
            PA_PULLUP[g] <= 1'b0;
         end else begin
            pa_oe_reg[g] <= pa_dir_reg[g] & (~pa_pu_reg[g] | ~pa_latch_reg[g]);
            pa_out_reg[g] <= pa_dir_reg[g] & ~pa_pu_reg[g] & pa_latch_reg[g];
            PA_PULLUP[g] <= pa_pu_reg[g];
         end
      end
   end

   for (g = 0; g < 5; g++) begin : g_pb_pin
      always_ff @(posedge MCLK) begin
         if (!RSTN) begin
            pb_oe_reg[g] <= 1'b0;
            pb_out_reg[g] <= 1'b0;
            PB_PULLUP[g] <= 1'b0;
         end else begin
            pb_oe_reg[g] <= pb_dir_eff[g] & (~pb_pu_eff[g] | ~pb_latch_reg[g]);
            pb_out_reg[g] <= pb_dir_eff[g] & ~pb_pu_eff[g] & pb_latch_reg[g];
            PB_PULLUP[g] <= pb_pu_eff[g];
         end
      end
   end

   // Slow-edge enables only shape the driver; they feed nothing of direction or pull-up.
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         PA_SLOW <= '0;
         PB_SLOW <= '0;
      end else begin
         PA_SLOW <= '0;
         PA_SLOW[PA_SLOW_LO_BIT] <= slow_a_reg;
         PA_SLOW[PA_SLOW_HI_BIT] <= slow_a_reg;
         PB_SLOW <= {PB_WIDTH{slow_b_reg}};
      end
   end

   assign PA_OE = pa_oe_reg;
   assign PA_OUT = pa_out_reg;
   assign PB_OE = pb_oe_reg;
   assign PB_OUT = pb_out_reg;
   assign AWREADY = awready_reg;
   assign WREADY = wready_reg;
   assign BVALID = bvalid_reg;
   assign BRESP = bresp_reg;
   assign ARREADY = arready_reg;
   assign RVALID = rvalid_reg;
   assign RRESP = rresp_reg;
   assign RDATA = rdata_reg;

   // Every pin output above is registered, so pins follow a register write one edge later.
   // Software that needs a pin settled before reading it back should allow for that edge.
   // The interrupt status keeps an event that lands in the cycle of its own clear.

endmodule : dual_bidirectional_io_ports

`default_nettype wire

/* design/gpio_ports_pkg.sv */
`default_nettype none

package gpio_ports_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [4:0] IDX_PA_DATA = 5'h00;
   localparam logic [4:0] IDX_PB_DATA = 5'h01;
   localparam logic [4:0] IDX_PA_DIR = 5'h04;
   localparam logic [4:0] IDX_PB_DIR = 5'h05;
   localparam logic [4:0] IDX_PA_PULLUP = 5'h10;
   localparam logic [4:0] IDX_PB_PULLUP = 5'h11;
   localparam logic [4:0] IDX_IRQ_STATUS = 5'h12;
   localparam logic [4:0] IDX_IRQ_CLEAR = 5'h13;
   localparam logic [4:0] IDX_IRQ_ENABLE = 5'h14;
   localparam logic [4:0] IDX_CONV_CTRL = 5'h15;

   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;

   // Documented port widths.
   localparam int PA_PINS = 8;
   localparam int PB_PINS = 5;

   // Field positions in the second port's direction register.
   localparam int PB_DIR_SLOW_A_BIT = 7;
   localparam int PB_DIR_SLOW_B_BIT = 6;

   // First-port pins with slow falling edge.
   localparam int PA_SLOW_LO_BIT = 6;
   localparam int PA_SLOW_HI_BIT = 7;

   // Interrupt-source pins on the first port.
   localparam int PA_PRIMARY_LO_BIT = 0;
   localparam int PA_PRIMARY_HI_BIT = 3;
   localparam int PA_SECONDARY_BIT = 4;

   // Second-port pins shared with other functions.
   localparam int PB_CAPTURE_BIT = 0;
   localparam int PB_CONV_FOUR_BIT = 3;
   localparam int PB_CONV_FIVE_BIT = 4;

   // Converter control register fields.
   localparam int CONV_ON_BIT = 0;
   localparam int CONV_SEL_FOUR_BIT = 1;
   localparam int CONV_SEL_FIVE_BIT = 2;

   // Interrupt status bit positions.
   localparam int IRQ_PRIMARY_BIT = 0;
   localparam int IRQ_SECONDARY_BIT = 1;
   localparam int IRQ_BITS = 2;

   // Reset values.
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_PULLUP = 8'h00;
   localparam logic [1:0] RST_IRQ = 2'h0;
   localparam logic [2:0] RST_CONV = 3'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gpio_ports_pkg

`default_nettype wire

/* sim/dual_bidirectional_io_ports_tb.sv */
`default_nettype none

module dual_bidirectional_io_ports_tb;
   import gpio_ports_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic MCLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID;
   logic ARREADY, RVALID, PRIMARY_EXT_IRQ, SECONDARY_EXT_IRQ, CAPTURE_IN, IRQ;
   logic [7:0] AWADDR, ARADDR, PA_IN, PA_OUT, PA_OE, PA_PULLUP, PA_SLOW, pa_en, pa_val;
   logic [4:0] PB_IN, PB_OUT, PB_OE, PB_PULLUP, PB_SLOW, pb_en, pb_val;
   logic [31:0] WDATA, RDATA, rd_data;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   logic [7:0] dat_a[2] = '{8'h00, 8'h04};
   logic [7:0] dir_a[2] = '{8'h10, 8'h14};
   logic [7:0] pu_a[2] = '{8'h40, 8'h44};
   logic [7:0] l, d, u, v, m, keep;
   int err_count = 0;
   int checks = 0;

   dual_bidirectional_io_ports dual_bidirectional_io_ports_inst (.MCLK, .RSTN, .AWADDR,
      .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
      .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .PA_IN, .PA_OUT, .PA_OE,
      .PA_PULLUP, .PA_SLOW, .PB_IN, .PB_OUT, .PB_OE, .PB_PULLUP, .PB_SLOW, .PRIMARY_EXT_IRQ,
      .SECONDARY_EXT_IRQ, .CAPTURE_IN, .IRQ);
   pin_board #(.W(8)) board_a_inst (.clk(MCLK), .oe(PA_OE), .out(PA_OUT), .pu(PA_PULLUP),
      .ext_en(pa_en), .ext_val(pa_val), .level(PA_IN));
   pin_board #(.W(5)) board_b_inst (.clk(MCLK), .oe(PB_OE), .out(PB_OUT), .pu(PB_PULLUP),
      .ext_en(pb_en), .ext_val(pb_val), .level(PB_IN));

   initial begin
      MCLK = 1'b0;
      forever #25 MCLK = ~MCLK;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Bounded waits: a slave that never answers ends the run as a mismatch.
   task automatic wr(input logic [7:0] a, input logic [7:0] dv, input logic [1:0] er);
      int n;
      n = 0;
      AWADDR <= a;
      WDATA <= {24'h000000, dv};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      while (n < 60) begin
         @(posedge MCLK);
         n++;
         if (AWVALID && AWREADY === 1'b1) AWVALID <= 1'b0;
         if (WVALID && WREADY === 1'b1) WVALID <= 1'b0;
         if (BVALID === 1'b1) break;
      end
      if (BVALID !== 1'b1) begin
         chk("write answer", 0, 1);
         print_verdict();
      end
      chk("bresp", BRESP, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      n = 0;
      ARADDR <= a;
      ARVALID <= 1'b1;
      while (n < 60) begin
         @(posedge MCLK);
         n++;
         if (ARVALID && ARREADY === 1'b1) ARVALID <= 1'b0;
         if (RVALID === 1'b1) break;
      end
      if (RVALID !== 1'b1) begin
         chk("read answer", 0, 1);
         print_verdict();
      end
      chk("rresp", RRESP, er);
      chk("rdata", RDATA, exp);
   endtask

   task automatic settle;
      repeat (3) @(posedge MCLK);
   endtask

   initial begin
      {AWADDR, ARADDR, WDATA, AWVALID, WVALID, ARVALID} = '0;
      WSTRB = 4'hF;
      {RSTN, BREADY, RREADY} = 3'b011;
      {pa_en, pa_val, pb_en, pb_val} = {8'hFF, 8'hFF, 5'h1F, 5'h1F};
      void'($urandom(32'hDE49A591));
      repeat (4) @(posedge MCLK);
      RSTN <= 1'b1;
      repeat (2) @(posedge MCLK);
      chk("pa oe", PA_OE, 0);
      rd(8'h10, 0, RESP_OKAY);
      rd(8'h14, 0, RESP_OKAY);
      rd(8'h0C, 0, RESP_SLVERR);
      wr(8'h3C, 8'h55, RESP_SLVERR);
      for (int i = 0; i < 24; i++) begin
         m = (i % 2) ? 8'h1F : 8'hFF;
         {l, d, u, v} = {$urandom} & {m, m, m, m};
         if (i % 2) pb_val <= v[4:0];
         else pa_val <= v;
         wr(dat_a[i%2], l, RESP_OKAY);
         wr(pu_a[i%2], u, RESP_OKAY);
         wr(dir_a[i%2], d, RESP_OKAY);
         settle();
         chk("oe", (i % 2) ? PB_OE : PA_OE, d & (~u | ~l));
         chk("drive", (i % 2) ? PB_OE & PB_OUT : PA_OE & PA_OUT, d & l & ~u);
         chk("pullup", (i % 2) ? PB_PULLUP : PA_PULLUP, u);
         rd(dat_a[i%2], (d & l) | (~d & v & m), RESP_OKAY);
         rd(dir_a[i%2], d, RESP_OKAY);
      end
      keep = PA_OE;
      wr(8'h14, 8'hE3, RESP_OKAY);
      settle();
      chk("pa slow", PA_SLOW, 8'hC0);
      chk("pb slow", PB_SLOW, 5'h1F);
      chk("pa oe kept", PA_OE, keep);
      rd(8'h14, 8'hC3, RESP_OKAY);
      pb_val <= 5'h1F;
      wr(8'h14, 8'h00, RESP_OKAY);
      wr(8'h44, 8'h00, RESP_OKAY);
      wr(8'h04, 8'h00, RESP_OKAY);
      settle();
      chk("slow off", {PA_SLOW, 3'h0, PB_SLOW}, 0);
      chk("capture in", CAPTURE_IN, 1);
      wr(8'h14, 8'h01, RESP_OKAY);
      settle();
      chk("capture out", CAPTURE_IN, 0);
      wr(8'h14, 8'h18, RESP_OKAY);
      wr(8'h44, 8'h18, RESP_OKAY);
      wr(8'h54, 8'h07, RESP_OKAY);
      settle();
      chk("conv oe", PB_OE[4:3], 0);
      chk("conv pullup", PB_PULLUP[4:3], 0);
      rd(8'h14, 8'h18, RESP_OKAY);
      wr(8'h54, 8'h00, RESP_OKAY);
      settle();
      chk("conv off oe", PB_OE[4:3], 2'b11);
      pa_val <= 8'hFF;
      wr(8'h10, 8'h00, RESP_OKAY);
      wr(8'h50, 8'h03, RESP_OKAY);
      wr(8'h4C, 8'h03, RESP_OKAY);
      settle();
      chk("irq idle", IRQ, 0);
      pa_val <= 8'hFB;
      settle();
      chk("primary", {PRIMARY_EXT_IRQ, IRQ}, 2'b11);
      rd(8'h48, 1, RESP_OKAY);
      wr(8'h50, 8'h02, RESP_OKAY);
      settle();
      chk("masked", IRQ, 0);
      pa_val <= 8'hEF;
      wr(8'h4C, 8'h01, RESP_OKAY);
      settle();
      chk("secondary", {SECONDARY_EXT_IRQ, IRQ}, 2'b11);
      rd(8'h48, 2, RESP_OKAY);
      pa_val <= 8'hFF;
      wr(8'h00, 8'hFF, RESP_OKAY);
      wr(8'h40, 8'h00, RESP_OKAY);
      wr(8'h10, 8'h1F, RESP_OKAY);
      wr(8'h4C, 8'h03, RESP_OKAY);
      pa_val <= 8'hE0;
      settle();
      chk("out no irq", {PRIMARY_EXT_IRQ, SECONDARY_EXT_IRQ}, 0);
      rd(8'h48, 0, RESP_OKAY);
      wr(8'h00, 8'h3C, RESP_OKAY);
      RSTN <= 1'b0;
      repeat (4) @(posedge MCLK);
      RSTN <= 1'b1;
      pa_en <= 8'h00;
      repeat (2) @(posedge MCLK);
      chk("oe reset", PA_OE, 0);
      wr(8'h10, 8'hFF, RESP_OKAY);
      settle();
      chk("latch kept", PA_OUT, 8'h3C);
      rd(8'h00, 8'h3C, RESP_OKAY);
      print_verdict();
   end
endmodule // dual_bidirectional_io_ports_tb

`default_nettype wire

/* sim/gpio_ports_sva.sv */
`default_nettype none

module gpio_ports_chk
   import gpio_ports_pkg::*;
#(
   parameter int PA_WIDTH = PA_PINS,
   parameter int PB_WIDTH = PB_PINS
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   input wire logic [PA_WIDTH-1:0] PA_IN,
   input wire logic [PA_WIDTH-1:0] PA_OUT,
   input wire logic [PA_WIDTH-1:0] PA_OE,
   input wire logic [PA_WIDTH-1:0] PA_PULLUP,
   input wire logic [PA_WIDTH-1:0] PA_SLOW,
   input wire logic [PB_WIDTH-1:0] PB_OUT,
   input wire logic [PB_WIDTH-1:0] PB_OE,
   input wire logic [PB_WIDTH-1:0] PB_PULLUP,
   input wire logic [PB_WIDTH-1:0] PB_SLOW,
   input wire logic PRIMARY_EXT_IRQ,
   input wire logic SECONDARY_EXT_IRQ,
   input wire logic CAPTURE_IN
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RSTN);

   slow_a_pins_a: assert property (PA_SLOW[5:0] == 6'h00 && PA_SLOW[7] == PA_SLOW[6])
      else $error("slow edge shows on wrong first-port pins");
   slow_b_pins_a: assert property (PB_SLOW == {PB_WIDTH{PB_SLOW[0]}})
      else $error("second-port slow edges disagree");
   slow_keeps_cfg_a: assert property ($changed(PA_SLOW) |-> $stable(PA_OE) && $stable(PA_PULLUP))
      else $error("slow edge change moved pin configuration");
   od_low_only_a: assert property (((PA_OE & PA_PULLUP & PA_OUT) == '0) && ((PB_OE & PB_PULLUP & PB_OUT) == '0))
      else $error("open-drain pin driven high");
   capture_low_a: assert property (PB_OE[0] && $past(PB_OE[0]) |-> !CAPTURE_IN)
      else $error("capture input not held low on output pin");
   primary_idle_a: assert property ((PA_IN[3:0] == 4'hF) [*2] |=> !PRIMARY_EXT_IRQ)
      else $error("primary interrupt without a low pin");
   secondary_idle_a: assert property (PA_IN[4] ##1 PA_IN[4] |=> !SECONDARY_EXT_IRQ)
      else $error("secondary interrupt without a low pin");
   reset_clear_a: assert property ($rose(RSTN) |-> PA_OE == '0 && PB_OE == '0 && PA_PULLUP == '0 && !RVALID)
      else $error("pins not inputs after reset");
   read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read not answered in one cycle");

   slow_on_c: cover property (PA_SLOW[7] && PB_SLOW[0]);
   primary_c: cover property (PRIMARY_EXT_IRQ);
   capture_c: cover property (CAPTURE_IN ##1 !CAPTURE_IN);
endmodule // gpio_ports_chk

bind dual_bidirectional_io_ports gpio_ports_chk #(.PA_WIDTH(PA_WIDTH), .PB_WIDTH(PB_WIDTH))
   chk_inst (.MCLK, .RSTN, .ARVALID, .ARREADY, .RVALID, .PA_IN, .PA_OUT, .PA_OE, .PA_PULLUP,
   .PA_SLOW, .PB_OUT, .PB_OE, .PB_PULLUP, .PB_SLOW, .PRIMARY_EXT_IRQ, .SECONDARY_EXT_IRQ,
   .CAPTURE_IN);

`default_nettype wire

/* sim/pin_board.sv */
`default_nettype none

module pin_board #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic [W-1:0] oe,
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] pu,
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic flt = 1'b0;

   // A floating pin toggles so that a design never reads a stale level as valid.
   always_ff @(posedge clk) begin
      flt <= ~flt;
   end

   // The board may overpower a driven pin, which shows a read of latch versus pin.
   always_comb begin
      for (int i = 0; i < W; i++) begin
         level[i] = ext_en[i] ? ext_val[i] : oe[i] ? out[i] : pu[i] ? 1'b1 : flt;
      end
   end
endmodule // pin_board

`default_nettype wire
